/* File: comm_sfr_cfg.svh */
// register indices, field positions, reset values and counts for the comm sfr bank
// assumes byte address = 4 * index on a 32-bit bus, data in the low byte
`ifndef COMM_SFR_CFG_SVH
`define COMM_SFR_CFG_SVH

// register indices
`define IDX_SERIAL_MODE 8'h84
`define IDX_CH0_CONTROL 8'h92
`define IDX_CH1_CONTROL 8'h93
`define IDX_BAUD 8'h94
`define IDX_MATCH_0 8'h95
`define IDX_MATCH_1 8'ha5
`define IDX_IRQ_EN_PRI 8'ha8
`define IDX_MATCH_2 8'hb5
`define IDX_CH0_DEST_LO 8'hc2
`define IDX_CH0_DEST_HI 8'hc3
`define IDX_BACKOFF 8'hc4
`define IDX_MATCH_3 8'hc5
`define IDX_IRQ_EN_SEC 8'hc8
`define IDX_CH1_DEST_LO 8'hd2
`define IDX_CH1_DEST_HI 8'hd3
`define IDX_MASK_0 8'hd5
`define IDX_CH0_COUNT_LO 8'he2
`define IDX_CH0_COUNT_HI 8'he3
`define IDX_MASK_1 8'he5
`define IDX_CH1_COUNT_LO 8'hf2
`define IDX_CH1_COUNT_HI 8'hf3
// step between channel 0 and channel 1 registers
`define CH_STEP_DATA 8'h10
`define CH_STEP_CTL 8'h01

// field positions
`define BIT_GLOBAL_IRQ_GATE 7
`define BIT_DONE 1

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// preamble lengths in bits for the two preamble bits
`define PRE_LEN_0 7'h00
`define PRE_LEN_1 7'h08
`define PRE_LEN_2 7'h20
`define PRE_LEN_3 7'h40

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: comm_sfr_pkg.sv */
// types shared by the comm sfr bank: mode layouts, decoded serial setup, states
// assumes comm_sfr_cfg.svh carries the numbers
package comm_sfr_pkg;

  typedef struct packed {
    logic ext_tx_clock_sel;
    logic backoff_mode_hi;
    logic backoff_mode_lo;
    logic addr_length_sel;
    logic crc_type_sel;
    logic preamble_len_hi;
    logic preamble_len_lo;
    logic protocol_sel;
  } serial_mode_t;

  typedef struct packed {
    logic dest_space_sel;
    logic dest_auto_inc;
    logic src_space_sel;
    logic src_auto_inc;
    logic demand_sel;
    logic transfer_mode_sel;
    logic done;
    logic enable;
  } channel_control_t;

  typedef enum logic [1:0] {
    MODE_ALT_CYCLES = 2'b00,
    MODE_BURST = 2'b01,
    MODE_SERIAL_DEMAND = 2'b10,
    MODE_EXT_DEMAND = 2'b11
  } dma_mode_t;

  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_WAIT_IFS = 2'b01,
    BK_COUNT = 2'b11
  } backoff_state_t;

  typedef struct packed {
    logic sdlc;
    logic [6:0] preamble_bits;
    logic crc32;
    logic addr16;
    logic raw_rx;
    logic raw_tx;
    logic alt_backoff;
    logic ext_tx_clk;
    logic preamble_illegal;
  } serial_cfg_t;

endpackage : comm_sfr_pkg

/* File: comm_dma_serial_sfr_bank.sv */
// register bank for the serial channel and the two dma channels, on an axi4-lite slave
// assumes one clock; pins ext_tx_clk_i, ext_dreq_i and rx_pin_i are asynchronous
// Notes on behaviour
// - byte mode: any of four match registers accepts
// - two-byte mode: pairs 1+2 or 3+2 accept
// - all-ones address is broadcast, both modes
// - mask bit one makes match bit don't-care
// - baud writes reload register; reads live count
// - 16-bit transfer count per channel, 0..65535
// - 16-bit destination address per channel
// - backoff timer counts slots; writes ignored
// - control bits 7:6 select destination space
// - control bits 5:4 select source space
// - demand and transfer bits select channel mode
// - enable bit starts or enables the channel
// - done sets at zero count, clears on vector
// - protocol bit: one sdlc, zero csma/cd
// - preamble 0/8/32/64; zero illegal in csma
// - crc bit: one 32-bit, zero 16-bit
// - address bit: one two-byte, zero byte
// - raw receive passes all bytes incl crc
// - raw transmit echoes receive input unframed
// - alternate backoff waits for interframe spacing end
// - transmit clock from pin or baud generator
// - global gate and per-source enable bits
// - secondary bits 1,0 enable rx error/valid
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "comm_sfr_cfg.svh"
`default_nettype none

module comm_dma_serial_sfr_bank #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // station address check
  input wire logic rx_addr_valid_i,
  input wire logic [15:0] rx_addr_i,
  output logic addr_check_done_o,
  output logic addr_accept_o,
  // serial channel setup and data path
  output comm_sfr_pkg::serial_cfg_t serial_cfg_o,
  input wire logic ext_tx_clk_i,
  output logic tx_bit_tick_o,
  input wire logic rx_pin_i,
  input wire logic tx_serial_i,
  output logic tx_pin_o,
  // collision backoff
  input wire logic backoff_start_i,
  input wire logic [7:0] backoff_seed_i,
  input wire logic slot_tick_i,
  input wire logic ifs_done_i,
  output logic backoff_busy_o,
  // dma channels
  input wire logic [1:0] serial_flag_i,
  input wire logic [1:0] ext_dreq_i,
  input wire logic [1:0] xfer_ack_i,
  input wire logic [1:0] irq_vector_ack_i,
  output logic [1:0] dma_req_o,
  output comm_sfr_pkg::dma_mode_t [1:0] dma_mode_o,
  output comm_sfr_pkg::channel_control_t [1:0] dma_ctl_o,
  output logic [1:0][15:0] dma_dest_o,
  output logic [1:0][15:0] dma_count_o,
  // interrupt sources and gated requests
  input wire logic [4:0] irq_src_pri_i,
  input wire logic [3:0] irq_src_serial_i,
  output logic [10:0] irq_req_o
);

  // index hit on a byte address
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    idx_hit = (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction : idx_hit

  // masked byte compare; a one in the mask is a don't-care
  function automatic logic byte_match(input logic [7:0] a, input logic [7:0] r,
                                      input logic [7:0] m);
    byte_match = (((a ^ r) & ~m) == 8'h00);
  endfunction : byte_match

  // register state
  comm_sfr_pkg::serial_mode_t mode_q;
  comm_sfr_pkg::channel_control_t ctl_q [2];
  logic [7:0] match_q [4];
  logic [7:0] mask_q [2];
  logic [7:0] irq_en_pri_q;
  logic [7:0] irq_en_sec_q;
  logic [7:0] baud_reload_q;
  logic [7:0] baud_cnt_q;
  logic [7:0] backoff_q;
  logic [15:0] count_q [2];
  logic [15:0] dest_q [2];
  comm_sfr_pkg::backoff_state_t bk_state_q;

  // write channel capture
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic do_write;
  logic wr_mapped;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  // address and data are taken in either order, response after both
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= `RST_BYTE;
      wlane_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // byte lane 0 must be strobed for a register to change
  function automatic logic wr_to(input logic [7:0] idx);
    wr_to = do_write && wlane_q && idx_hit(waddr_q, idx);
  endfunction : wr_to

  // read decode, also used to tell mapped from unmapped writes
  function automatic logic [8:0] read_mux(input logic [ADDR_W-1:0] a);
    read_mux = {1'b1, `RST_BYTE};
    if (a[1:0] != 2'b00)
      read_mux = 9'h000;
    else
    begin
      case (a[9:2])
        `IDX_SERIAL_MODE: read_mux[7:0] = mode_q;
        `IDX_CH0_CONTROL: read_mux[7:0] = ctl_q[0];
        `IDX_CH1_CONTROL: read_mux[7:0] = ctl_q[1];
        `IDX_BAUD: read_mux[7:0] = baud_cnt_q;
        `IDX_MATCH_0: read_mux[7:0] = match_q[0];
        `IDX_MATCH_1: read_mux[7:0] = match_q[1];
        `IDX_IRQ_EN_PRI: read_mux[7:0] = irq_en_pri_q;
        `IDX_MATCH_2: read_mux[7:0] = match_q[2];
        `IDX_CH0_DEST_LO: read_mux[7:0] = dest_q[0][7:0];
        `IDX_CH0_DEST_HI: read_mux[7:0] = dest_q[0][15:8];
        `IDX_BACKOFF: read_mux[7:0] = backoff_q;
        `IDX_MATCH_3: read_mux[7:0] = match_q[3];
        `IDX_IRQ_EN_SEC: read_mux[7:0] = irq_en_sec_q;
        `IDX_CH1_DEST_LO: read_mux[7:0] = dest_q[1][7:0];
        `IDX_CH1_DEST_HI: read_mux[7:0] = dest_q[1][15:8];
        `IDX_MASK_0: read_mux[7:0] = mask_q[0];
        `IDX_CH0_COUNT_LO: read_mux[7:0] = count_q[0][7:0];
        `IDX_CH0_COUNT_HI: read_mux[7:0] = count_q[0][15:8];
        `IDX_MASK_1: read_mux[7:0] = mask_q[1];
        `IDX_CH1_COUNT_LO: read_mux[7:0] = count_q[1][7:0];
        `IDX_CH1_COUNT_HI: read_mux[7:0] = count_q[1][15:8];
        default: read_mux = 9'h000;
      endcase
    end
  endfunction : read_mux

  // decode through variables, a function result cannot be sliced
  logic [8:0] wr_dec;
  logic [8:0] rd_dec;
  always_comb
  begin
    wr_dec = read_mux(waddr_q);
    rd_dec = read_mux(s_axi_araddr);
  end
  assign wr_mapped = wr_dec[8];
  assign s_axi_arready = !s_axi_rvalid;

  // read answer one cycle after the address is taken; unmapped gives slverr and zero
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_dec[7:0]};
      s_axi_rresp <= rd_dec[8] ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // plain configuration registers
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode_q <= `RST_BYTE;
      irq_en_pri_q <= `RST_BYTE;
      irq_en_sec_q <= `RST_BYTE;
      baud_reload_q <= `RST_BYTE;
      match_q <= '{default: `RST_BYTE};
      mask_q <= '{default: `RST_BYTE};
    end
    else
    begin
      if (wr_to(`IDX_SERIAL_MODE)) mode_q <= wdata_q;
      if (wr_to(`IDX_IRQ_EN_PRI)) irq_en_pri_q <= wdata_q;
      if (wr_to(`IDX_IRQ_EN_SEC)) irq_en_sec_q <= wdata_q;
      if (wr_to(`IDX_BAUD)) baud_reload_q <= wdata_q;
      if (wr_to(`IDX_MATCH_0)) match_q[0] <= wdata_q;
      if (wr_to(`IDX_MATCH_1)) match_q[1] <= wdata_q;
      if (wr_to(`IDX_MATCH_2)) match_q[2] <= wdata_q;
      if (wr_to(`IDX_MATCH_3)) match_q[3] <= wdata_q;
      if (wr_to(`IDX_MASK_0)) mask_q[0] <= wdata_q;
      if (wr_to(`IDX_MASK_1)) mask_q[1] <= wdata_q;
    end
  end

  // baud timer counts down every clock and reloads on reaching zero
  logic baud_zero;
  assign baud_zero = (baud_cnt_q == 8'h00);
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      baud_cnt_q <= `RST_BYTE;
    else if (baud_zero)
      baud_cnt_q <= baud_reload_q;
    else
      baud_cnt_q <= baud_cnt_q - 8'h01;
  end

  // decoded serial setup, from flops so the outputs are clean
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      serial_cfg_o <= '0;
    else
    begin
      serial_cfg_o.sdlc <= mode_q.protocol_sel;
      case ({mode_q.preamble_len_hi, mode_q.preamble_len_lo})
        2'b00: serial_cfg_o.preamble_bits <= `PRE_LEN_0;
        2'b01: serial_cfg_o.preamble_bits <= `PRE_LEN_1;
        2'b10: serial_cfg_o.preamble_bits <= `PRE_LEN_2;
        default: serial_cfg_o.preamble_bits <= `PRE_LEN_3;
      endcase
      serial_cfg_o.preamble_illegal <= !mode_q.protocol_sel && !mode_q.preamble_len_hi
                                       && !mode_q.preamble_len_lo;
      serial_cfg_o.crc32 <= mode_q.crc_type_sel;
      serial_cfg_o.addr16 <= mode_q.addr_length_sel;
      serial_cfg_o.raw_rx <= mode_q.backoff_mode_hi && !mode_q.backoff_mode_lo;
      serial_cfg_o.raw_tx <= !mode_q.backoff_mode_hi && mode_q.backoff_mode_lo;
      serial_cfg_o.alt_backoff <= mode_q.backoff_mode_hi && mode_q.backoff_mode_lo;
      serial_cfg_o.ext_tx_clk <= mode_q.ext_tx_clock_sel;
    end
  end

  // two-flop synchronisers for the asynchronous pins, plus an edge stage for the clock
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic ext_clk_s3_q;
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      ext_clk_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= {ext_dreq_i, rx_pin_i, ext_tx_clk_i, 1'b0};
      pin_s2_q <= pin_s1_q;
      ext_clk_s3_q <= pin_s2_q[1];
    end
  end

  // transmit bit tick and raw-transmit echo; raw echo adds two clocks of sync delay
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_bit_tick_o <= 1'b0;
      tx_pin_o <= 1'b1;
    end
    else
    begin
      tx_bit_tick_o <= mode_q.ext_tx_clock_sel ? (pin_s2_q[1] && !ext_clk_s3_q)
                                                : baud_zero;
      tx_pin_o <= serial_cfg_o.raw_tx ? pin_s2_q[2] : tx_serial_i;
    end
  end

  // station address check, answered one clock after the strobe
  logic hit8;
  logic hit16;
  logic bcast;
  assign hit8 = byte_match(rx_addr_i[7:0], match_q[0], mask_q[0])
             || byte_match(rx_addr_i[7:0], match_q[1], mask_q[0])
             || byte_match(rx_addr_i[7:0], match_q[2], mask_q[0])
             || byte_match(rx_addr_i[7:0], match_q[3], mask_q[0]);
  assign hit16 = byte_match(rx_addr_i[15:8], match_q[2], mask_q[1])
              && (byte_match(rx_addr_i[7:0], match_q[1], mask_q[0])
              || byte_match(rx_addr_i[7:0], match_q[3], mask_q[0]));
  assign bcast = mode_q.addr_length_sel ? (rx_addr_i == 16'hffff)
                                        : (rx_addr_i[7:0] == 8'hff);
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      addr_check_done_o <= 1'b0;
      addr_accept_o <= 1'b0;
    end
    else
    begin
      addr_check_done_o <= rx_addr_valid_i;
      if (rx_addr_valid_i)
        addr_accept_o <= bcast || (mode_q.addr_length_sel ? hit16 : hit8);
    end
  end

  // collision backoff: alternate mode holds the start until spacing is over
  assign backoff_busy_o = (bk_state_q != comm_sfr_pkg::BK_IDLE);
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bk_state_q <= comm_sfr_pkg::BK_IDLE;
      backoff_q <= `RST_BYTE;
    end
    else
    begin
      case (bk_state_q)
        comm_sfr_pkg::BK_IDLE:
          if (backoff_start_i)
          begin
            backoff_q <= backoff_seed_i;
            bk_state_q <= serial_cfg_o.alt_backoff ? comm_sfr_pkg::BK_WAIT_IFS
                                                   : comm_sfr_pkg::BK_COUNT;
          end
        comm_sfr_pkg::BK_WAIT_IFS:
          if (ifs_done_i)
            bk_state_q <= comm_sfr_pkg::BK_COUNT;
        comm_sfr_pkg::BK_COUNT:
          if (backoff_q == 8'h00)
            bk_state_q <= comm_sfr_pkg::BK_IDLE;
          else if (slot_tick_i)
            backoff_q <= backoff_q - 8'h01;
        default: bk_state_q <= comm_sfr_pkg::BK_IDLE;
      endcase
    end
  end

  // dma channels; a software data write wins over a transfer step in the same cycle
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    localparam logic [7:0] DOFF = (ch == 0) ? 8'h00 : `CH_STEP_DATA;
    localparam logic [7:0] COFF = (ch == 0) ? 8'h00 : `CH_STEP_CTL;
    logic trigger;
    logic done_set;
    logic done_clr;
    logic started_q;
    comm_sfr_pkg::dma_mode_t mode;

    assign mode = comm_sfr_pkg::dma_mode_t'({ctl_q[ch].demand_sel,
                                             ctl_q[ch].transfer_mode_sel});
    always_comb
    begin
      case (mode)
        comm_sfr_pkg::MODE_SERIAL_DEMAND: trigger = serial_flag_i[ch];
        comm_sfr_pkg::MODE_EXT_DEMAND: trigger = pin_s2_q[3+ch];
        default: trigger = 1'b1;
      endcase
    end
    assign dma_req_o[ch] = ctl_q[ch].enable && trigger && (count_q[ch] != 16'h0000);
    assign dma_mode_o[ch] = mode;
    assign dma_ctl_o[ch] = ctl_q[ch];
    assign dma_dest_o[ch] = dest_q[ch];
    assign dma_count_o[ch] = count_q[ch];
    // done sets on the last byte, or when enabled with nothing to move
    assign done_set = (xfer_ack_i[ch] && count_q[ch] == 16'h0001)
                   || (ctl_q[ch].enable && !started_q && count_q[ch] == 16'h0000);
    // a process, not an assign, so the write strobes read inside wr_to are followed
    always_comb
    begin
      done_clr = irq_vector_ack_i[ch]
              || (wr_to(`IDX_CH0_CONTROL + COFF) && !wdata_q[`BIT_DONE]);
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        ctl_q[ch] <= `RST_BYTE;
        started_q <= 1'b0;
      end
      else
      begin
        started_q <= ctl_q[ch].enable;
        if (wr_to(`IDX_CH0_CONTROL + COFF))
          ctl_q[ch] <= wdata_q;
        if (done_set)
          ctl_q[ch].done <= 1'b1;
        else if (done_clr)
          ctl_q[ch].done <= 1'b0;
      end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        count_q[ch] <= `RST_WORD;
        dest_q[ch] <= `RST_WORD;
      end
      else
      begin
        if (xfer_ack_i[ch] && count_q[ch] != 16'h0000)
          count_q[ch] <= count_q[ch] - 16'h0001;
        if (xfer_ack_i[ch] && ctl_q[ch].dest_auto_inc)
          dest_q[ch] <= dest_q[ch] + 16'h0001;
        if (wr_to(`IDX_CH0_COUNT_LO + DOFF)) count_q[ch][7:0] <= wdata_q;
        if (wr_to(`IDX_CH0_COUNT_HI + DOFF)) count_q[ch][15:8] <= wdata_q;
        if (wr_to(`IDX_CH0_DEST_LO + DOFF)) dest_q[ch][7:0] <= wdata_q;
        if (wr_to(`IDX_CH0_DEST_HI + DOFF)) dest_q[ch][15:8] <= wdata_q;
      end
    end
  end

  // interrupt gating; order {serial tx err, dma1, tx valid, dma0, rx err, rx valid, pri[4:0]}
  logic [5:0] sec_src;
  assign sec_src = {irq_src_serial_i[3], ctl_q[1].done, irq_src_serial_i[2], ctl_q[0].done,
                    irq_src_serial_i[1], irq_src_serial_i[0]};
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_req_o <= 11'h000;
    else if (!irq_en_pri_q[`BIT_GLOBAL_IRQ_GATE])
      irq_req_o <= 11'h000;
    else
      irq_req_o <= {sec_src & irq_en_sec_q[5:0], irq_src_pri_i & irq_en_pri_q[4:0]};
  end

  // checks
  property p_byte_accept;
    @(posedge mclk_i) disable iff (!reset_n_i)
    rx_addr_valid_i && !mode_q.addr_length_sel && hit8 |=> addr_accept_o;
  endproperty
  a_byte_accept: assert property (p_byte_accept) else $error("byte match refused");
  property p_pair_accept;
    @(posedge mclk_i) disable iff (!reset_n_i)
    rx_addr_valid_i && mode_q.addr_length_sel && !hit16 && rx_addr_i != 16'hffff
      |=> !addr_accept_o;
  endproperty
  a_pair_accept: assert property (p_pair_accept) else $error("bad pair accepted");
  property p_bcast;
    @(posedge mclk_i) disable iff (!reset_n_i)
    rx_addr_valid_i && rx_addr_i == 16'hffff |=> addr_check_done_o && addr_accept_o;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast refused");
  property p_baud_reload;
    @(posedge mclk_i) disable iff (!reset_n_i)
    baud_cnt_q == 8'h00 |=> baud_cnt_q == $past(baud_reload_q);
  endproperty
  a_baud_reload: assert property (p_baud_reload) else $error("baud not reloaded");
  property p_backoff_no_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
    bk_state_q != comm_sfr_pkg::BK_IDLE ##1 bk_state_q != comm_sfr_pkg::BK_IDLE
      |-> backoff_q <= $past(backoff_q);
  endproperty
  a_backoff_no_write: assert property (p_backoff_no_write) else $error("backoff rose");
  property p_req_needs_enable;
    @(posedge mclk_i) disable iff (!reset_n_i)
    dma_req_o[0] |-> ctl_q[0].enable && count_q[0] != 16'h0000;
  endproperty
  a_req_needs_enable: assert property (p_req_needs_enable) else $error("req off");
  property p_done_sets;
    @(posedge mclk_i) disable iff (!reset_n_i)
    xfer_ack_i[0] && count_q[0] == 16'h0001 && !wr_to(`IDX_CH0_COUNT_LO)
      |=> count_q[0] == 16'h0000 && ctl_q[0].done;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done not set");
  property p_alt_wait;
    @(posedge mclk_i) disable iff (!reset_n_i)
    bk_state_q == comm_sfr_pkg::BK_WAIT_IFS && !ifs_done_i |=> bk_state_q != comm_sfr_pkg::BK_COUNT;
  endproperty
  a_alt_wait: assert property (p_alt_wait) else $error("backoff before spacing");
  property p_global_gate;
    @(posedge mclk_i) disable iff (!reset_n_i)
    !irq_en_pri_q[`BIT_GLOBAL_IRQ_GATE] |=> irq_req_o == 11'h000;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("gate leaked");

endmodule : comm_dma_serial_sfr_bank

`default_nettype wire

/* File: cpu_bus.sv */
// axi4-lite master standing in for the processor core
// assumes one clock; bready and rready are held high by the bench
`timescale 1ns/1ps
`default_nettype none
module cpu_bus (
  // clock
  input wire logic clk_i,
  // write side
  output logic [9:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic bvalid_i,
  // read side
  output logic [9:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic rvalid_i,
  input wire logic [1:0] rresp_i,
  input wire logic [31:0] rdata_i
);
  // idle bus from time zero
  initial
  begin
    {awaddr_o, araddr_o, wdata_o} = '0;
    {awvalid_o, wvalid_o, arvalid_o} = 3'b000;
  end

  // address and data go out together; each drops once taken, no fixed latency assumed
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    awaddr_o <= {idx, 2'b00};
    wdata_o <= {24'h000000, d};
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end
    while (!bvalid_i);
  endtask : wr

  // one read, data and response taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= {idx, 2'b00};
    arvalid_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready_i) arvalid_o <= 1'b0;
    end
    while (!rvalid_i);
    d = rdata_i[7:0];
    r = rresp_i;
  endtask : rd
endmodule : cpu_bus
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the comm sfr bank
// assumes cpu_bus speaks the register bus and the cfg header gives indices
`timescale 1ns/1ps
`include "comm_sfr_cfg.svh"
`default_nettype none
module tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [9:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, acc, rx_v = 1'b0;
  logic [31:0] wdata, rdata, spare = 32'h00000000;
  logic [1:0] rresp, r, req, ack = 2'b00;
  logic [15:0] rx_a = 16'h0000;
  logic [4:0] src = 5'h00;
  logic [7:0] d;
  logic [10:0] irq;
  logic [7:0] regs [8] = '{`IDX_MATCH_0, `IDX_MATCH_1, `IDX_MATCH_2, `IDX_MATCH_3,
    `IDX_CH0_DEST_HI, `IDX_CH1_DEST_LO, `IDX_CH0_COUNT_HI, `IDX_CH1_COUNT_LO};
  comm_sfr_pkg::serial_cfg_t cfg;
  comm_sfr_pkg::dma_mode_t [1:0] mode;
  comm_sfr_pkg::channel_control_t [1:0] ctl;
  logic [1:0][15:0] cnt;
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  // 20 mhz core clock
  always #25 mclk_i = ~mclk_i;

  comm_dma_serial_sfr_bank comm_dma_serial_sfr_bank_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .rx_addr_valid_i(rx_v), .rx_addr_i(rx_a), .addr_check_done_o(), .addr_accept_o(acc),
    .serial_cfg_o(cfg), .ext_tx_clk_i(spare[0]), .tx_bit_tick_o(), .rx_pin_i(spare[1]),
    .tx_serial_i(spare[2]), .tx_pin_o(), .backoff_start_i(spare[3]),
    .backoff_seed_i(spare[11:4]), .slot_tick_i(spare[12]), .ifs_done_i(spare[13]),
    .backoff_busy_o(), .serial_flag_i(spare[15:14]), .ext_dreq_i(spare[17:16]),
    .xfer_ack_i(ack), .irq_vector_ack_i(spare[19:18]), .dma_req_o(req), .dma_mode_o(mode),
    .dma_ctl_o(ctl), .dma_dest_o(), .dma_count_o(cnt), .irq_src_pri_i(src),
    .irq_src_serial_i(spare[23:20]), .irq_req_o(irq));

  cpu_bus cpu_bus_i (.clk_i(mclk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
    .bvalid_i(bvalid), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rvalid_i(rvalid), .rresp_i(rresp), .rdata_i(rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one received address, verdict read a cycle later
  task automatic ck(input logic [15:0] a, input logic exp);
    @(posedge mclk_i);
    rx_a <= a;
    rx_v <= 1'b1;
    @(posedge mclk_i);
    rx_v <= 1'b0;
    @(negedge mclk_i);
    chk(acc, exp);
  endtask : ck

  task automatic print_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // hang guard, well above the run length
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      errors++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    foreach (regs[k])
    begin
      cpu_bus_i.wr(regs[k], regs[k] + 8'h01);
      cpu_bus_i.rd(regs[k], d, r);
      chk({d, r}, {regs[k] + 8'h01, 2'b00});
    end
    cpu_bus_i.wr(`IDX_BACKOFF, 8'h5a);
    cpu_bus_i.rd(`IDX_BACKOFF, d, r);
    chk({d, r}, 10'h000);
    cpu_bus_i.rd(8'h00, d, r);
    chk(r, 2'b10);
    cpu_bus_i.wr(`IDX_BAUD, 8'h03);
    cpu_bus_i.rd(`IDX_BAUD, d, r);
    chk(d <= 8'h03, 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      cpu_bus_i.wr(`IDX_CH1_CONTROL, {m[1:0], m[1:0], m[1:0], 2'b00});
      chk(ctl[1], {m[1:0], m[1:0], m[1:0], 2'b00});
      chk(mode[1], m[1:0]);
    end
    cpu_bus_i.wr(`IDX_CH0_COUNT_HI, 8'h00);
    cpu_bus_i.wr(`IDX_CH0_COUNT_LO, 8'h01);
    cpu_bus_i.wr(`IDX_CH0_CONTROL, 8'h01);
    chk(req[0], 1'b1);
    ack <= 2'b01;
    @(posedge mclk_i);
    ack <= 2'b00;
    repeat (2) @(negedge mclk_i);
    chk({cnt[0], ctl[0].done}, 17'h00001);
    @(posedge mclk_i);
    src <= 5'h01;
    cpu_bus_i.wr(`IDX_IRQ_EN_PRI, 8'h01);
    repeat (2) @(negedge mclk_i);
    chk(irq[0], 1'b0);
    cpu_bus_i.wr(`IDX_IRQ_EN_PRI, 8'h81);
    repeat (2) @(negedge mclk_i);
    chk(irq[0], 1'b1);
    ck(16'h00c6, 1'b1);
    ck(16'h0011, 1'b0);
    ck(16'h00ff, 1'b1);
    cpu_bus_i.wr(`IDX_MASK_0, 8'h0f);
    ck(16'h0091, 1'b1);
    cpu_bus_i.wr(`IDX_SERIAL_MODE, 8'h19);
    @(negedge mclk_i);
    chk({cfg.sdlc, cfg.crc32, cfg.addr16}, 3'h7);
    ck(16'hb6c6, 1'b1);
    ck(16'ha6b6, 1'b0);
    ck(16'hffff, 1'b1);
    cpu_bus_i.wr(`IDX_SERIAL_MODE, 8'h06);
    @(negedge mclk_i);
    chk(cfg.preamble_bits, 7'h40);
    cpu_bus_i.wr(`IDX_SERIAL_MODE, 8'h00);
    @(negedge mclk_i);
    chk(cfg.preamble_illegal, 1'b1);
    cpu_bus_i.wr(`IDX_SERIAL_MODE, 8'h60);
    @(posedge mclk_i);
    spare[13:3] <= 11'h207;
    @(posedge mclk_i);
    spare[3] <= 1'b0;
    cpu_bus_i.rd(`IDX_BACKOFF, d, r);
    chk(d, 8'h03);
    spare[13] <= 1'b1;
    repeat (8) @(posedge mclk_i);
    cpu_bus_i.rd(`IDX_BACKOFF, d, r);
    chk(d, 8'h00);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
